// ### rtl/psc_pkg.sv
package psc_pkg;
   // Clock period in picoseconds (200 MHz).
   localparam int CLK_PS = 5000;
   // Write and read cycle timing figures, in nanoseconds.
   localparam int T_WP_NS = 55;
   localparam int T_WP_LONG_NS = 70;
   localparam int T_WC_NS = 70;
   localparam int T_RC_NS = 70;
   localparam int T_DW_NS = 30;
   // Refresh window for short address toggling, in nanoseconds.
   localparam int T_REFRESH_NS = 4000;
   // Suspend interval before deep power down, in microseconds.
   localparam int T_SUSPEND_US = 500;
   // Wake-up wait after leaving deep power down, in microseconds.
   localparam int T_WAKE_US = 200;
   // Back-to-back write count from which the long pulse applies.
   localparam int LONG_WRITE_COUNT = 50;
   // Derived cycle counts; least times round up.
   localparam int WP_CYC = (T_WP_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int WP_LONG_CYC = (T_WP_LONG_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int WC_CYC = (T_WC_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int RC_CYC = (T_RC_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int DW_CYC = (T_DW_NS * 1000 + CLK_PS - 1) / CLK_PS;
   // Longest time, rounded down, with no margin taken off for a standby cycle slot.
   localparam int REFRESH_CYC = (T_REFRESH_NS * 1000) / CLK_PS;
   localparam int SUSPEND_CYC = (T_SUSPEND_US * 1000000 + CLK_PS - 1) / CLK_PS;
   localparam int WAKE_CYC = (T_WAKE_US * 1000000 + CLK_PS - 1) / CLK_PS;
   // Width of the shared cycle counter.
   localparam int CNT_W = 20;
   // Address and data widths of the port.
   localparam int ADDR_W = 21;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   // Controller states.
   typedef enum logic [2:0] {
      PSC_IDLE = 3'b000,
      PSC_SETUP = 3'b001,
      PSC_PULSE = 3'b010,
      PSC_RECOVER = 3'b011,
      PSC_STANDBY = 3'b100,
      PSC_SUSPEND = 3'b101,
      PSC_DOWN = 3'b110,
      PSC_WAKE = 3'b111
   } psc_state_t;
endpackage

// ### rtl/psc_host.sv
`timescale 1ns/10ps
// Behaviour
// - Single byte write asserts exactly one lane.
// - Word write asserts both lanes together.
// - Wake-up repeats power-up sequence before accesses.
// - Every 4 us allow one read-cycle standby.
// - From the 50th back-to-back write on, stretch pulse to 70 ns.
module psc_host #(
   parameter int SUSPEND_CYCLES = psc_pkg::SUSPEND_CYC,
   parameter int WAKE_CYCLES = psc_pkg::WAKE_CYC,
   parameter int REFRESH_CYCLES = psc_pkg::REFRESH_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [psc_pkg::ADDR_W-1:0] wr_addr,
   input wire logic [psc_pkg::DATA_W-1:0] wr_data,
   input wire logic [1:0] wr_lanes,
   input wire logic sleep_req,
   output logic asleep,
   output logic [psc_pkg::ADDR_W-1:0] mem_addr,
   output logic chip_select_n,
   output logic power_down_select,
   output logic write_enable_n,
   output logic output_enable_n,
   output logic upper_lane_select_n,
   output logic lower_lane_select_n,
   output logic [psc_pkg::DATA_W-1:0] mem_dq_out,
   output logic [1:0] mem_dq_oe
);
   import psc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State and counters.
   psc_state_t state_r; // Current controller state.
   logic [CNT_W-1:0] cnt_r; // Shared cycle counter for the current state.
   logic [CNT_W-1:0] refresh_r; // Cycles since the last standby slot, deep power down or wake.
   logic [6:0] burst_r; // Back-to-back write count, saturating.
   logic [1:0] lanes_r; // Latched lane enables, bit 1 upper.
   logic long_pulse; // Stretched write pulse is in force.

   // Pulse length depends on how long the write burst has run.
   assign long_pulse = (burst_r >= 7'(LONG_WRITE_COUNT));

   // A request is accepted only from idle, with no sleep request and no standby slot due.
   assign wr_ready = (state_r == PSC_IDLE) && !sleep_req && (refresh_r < CNT_W'(REFRESH_CYCLES));
   assign asleep = (state_r == PSC_DOWN);

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer for writes, refresh standby and power down.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= PSC_IDLE;
         cnt_r <= '0;
      end else begin
         unique case (state_r)
            PSC_IDLE: begin
               cnt_r <= '0;
               if (sleep_req) begin
                  state_r <= PSC_SUSPEND;
               end else if (refresh_r >= CNT_W'(REFRESH_CYCLES)) begin
                  state_r <= PSC_STANDBY;
               end else if (wr_valid && (wr_lanes != 2'b00)) begin
                  state_r <= PSC_SETUP;
               end
            end
            PSC_SETUP: begin
               // One cycle of address setup before the strobe falls.
               state_r <= PSC_PULSE;
               cnt_r <= '0;
            end
            PSC_PULSE: begin
               // Hold the strobe for the required pulse length.
               if ((long_pulse && cnt_r >= CNT_W'(WP_LONG_CYC - 1)) ||
                   (!long_pulse && cnt_r >= CNT_W'(WP_CYC - 1))) begin
                  state_r <= PSC_RECOVER;
                  cnt_r <= '0;
               end else begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            PSC_RECOVER: begin
               // Pad the cycle out to the full write-cycle time.
               if (cnt_r >= CNT_W'(WC_CYC - WP_CYC - 1)) begin
                  state_r <= PSC_IDLE;
               end
               cnt_r <= cnt_r + 1'b1;
            end
            PSC_STANDBY: begin
               // Deselect for one read-cycle time.
               if (cnt_r >= CNT_W'(RC_CYC - 1)) begin
                  state_r <= PSC_IDLE;
               end
               cnt_r <= cnt_r + 1'b1;
            end
            PSC_SUSPEND: begin
               // Power-down select low; wait out the suspend interval.
               if (cnt_r >= CNT_W'(SUSPEND_CYCLES - 1)) begin
                  state_r <= PSC_DOWN;
               end
               cnt_r <= cnt_r + 1'b1;
            end
            PSC_DOWN: begin
               // Stay down until the user releases the sleep request.
               cnt_r <= '0;
               if (!sleep_req) begin
                  state_r <= PSC_WAKE;
               end
            end
            PSC_WAKE: begin
               // Power-up wait with the chip deselected before any access.
               if (cnt_r >= CNT_W'(WAKE_CYCLES - 1)) begin
                  state_r <= PSC_IDLE;
               end
               cnt_r <= cnt_r + 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Refresh watchdog: counts up to the window, cleared in standby, deep power down and wake.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         refresh_r <= '0;
      end else if (state_r == PSC_STANDBY || state_r == PSC_DOWN || state_r == PSC_WAKE) begin
         refresh_r <= '0;
      end else if (refresh_r < CNT_W'(REFRESH_CYCLES)) begin
         refresh_r <= refresh_r + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Burst counter: back-to-back writes, reset by any idle gap.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         burst_r <= '0;
      end else if (state_r == PSC_IDLE && !(wr_valid && wr_ready)) begin
         burst_r <= '0;
      end else if (state_r == PSC_SETUP && !long_pulse) begin
         burst_r <= burst_r + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drivers, all from flip-flops.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_addr <= '0;
         mem_dq_out <= '0;
         lanes_r <= 2'b00;
      end else if (state_r == PSC_IDLE && wr_valid && wr_ready && wr_lanes != 2'b00) begin
         mem_addr <= wr_addr;
         mem_dq_out <= wr_data;
         lanes_r <= wr_lanes;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chip_select_n <= 1'b1;
         write_enable_n <= 1'b1;
         upper_lane_select_n <= 1'b1;
         lower_lane_select_n <= 1'b1;
         mem_dq_oe <= 2'b00;
         power_down_select <= 1'b1;
         output_enable_n <= 1'b1;
      end else begin
         output_enable_n <= 1'b1;
         // Power-down select is low through suspend and deep power down.
         power_down_select <= !((state_r == PSC_IDLE && sleep_req) ||
            (state_r == PSC_SUSPEND) || (state_r == PSC_DOWN && sleep_req));
         // Select and lanes cover setup and pulse; strobe covers setup and all but the last pulse cycle.
         chip_select_n <= !(state_r == PSC_SETUP ||
            (state_r == PSC_PULSE && state_r != PSC_RECOVER));
         write_enable_n <= !(state_r == PSC_SETUP ||
            (state_r == PSC_PULSE && !((long_pulse && cnt_r >= CNT_W'(WP_LONG_CYC - 1)) ||
            (!long_pulse && cnt_r >= CNT_W'(WP_CYC - 1)))));
         upper_lane_select_n <= !((state_r == PSC_SETUP || state_r == PSC_PULSE) && lanes_r[1]);
         lower_lane_select_n <= !((state_r == PSC_SETUP || state_r == PSC_PULSE) && lanes_r[0]);
         // Data driven while writing; memory floats its outputs then.
         mem_dq_oe <= (state_r == PSC_SETUP || state_r == PSC_PULSE) ? lanes_r : 2'b00;
      end
   end
endmodule

// ### test/psc_checker.sv
`timescale 1ns/10ps
module psc_checker import psc_pkg::*; #(
   parameter int REFRESH_CYCLES = 800
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] wr_lanes,
   input wire logic asleep,
   input wire logic chip_select_n,
   input wire logic power_down_select,
   input wire logic write_enable_n,
   input wire logic upper_lane_select_n,
   input wire logic lower_lane_select_n
);
   // Strobe-low run, select-high run and cycles since a full standby.
   logic [7:0] wl_r, hi_r;
   logic [CNT_W-1:0] gap_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wl_r <= 8'h00;
         hi_r <= 8'h00;
         gap_r <= '0;
      end else begin
         wl_r <= write_enable_n ? 8'h00 : wl_r + 8'h01;
         hi_r <= chip_select_n ? hi_r + 8'h01 : 8'h00;
         gap_r <= (hi_r >= 8'(RC_CYC)) ? '0 : gap_r + 1'b1;
      end
   end
   lane_map_a: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(chip_select_n) |->
      {upper_lane_select_n, lower_lane_select_n} == ~$past(wr_lanes, 2))
      else $error("lane mismatch");
   pulse_len_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(write_enable_n) |-> (wl_r == 8'(WP_CYC) || wl_r == 8'(WP_LONG_CYC)))
      else $error("bad pulse length");
   sleep_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
      asleep |-> chip_select_n && !power_down_select)
      else $error("selected while asleep");
   wake_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(power_down_select) |-> chip_select_n [*8])
      else $error("early access after wake");
   refresh_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
      gap_r <= CNT_W'(REFRESH_CYCLES + 2 * WC_CYC))
      else $error("standby missing");
endmodule
bind psc_host psc_checker #(.REFRESH_CYCLES(REFRESH_CYCLES)) i_chk (
   .clk, .rst_n, .wr_lanes, .asleep, .chip_select_n, .power_down_select,
   .write_enable_n, .upper_lane_select_n, .lower_lane_select_n);

// ### test/psc_mem_model.sv
`timescale 1ns/10ps
module psc_mem_model import psc_pkg::*; #(
   parameter int SUSPEND_NS = 500000
) (
   input wire logic [psc_pkg::ADDR_W-1:0] mem_addr,
   input wire logic chip_select_n,
   input wire logic power_down_select,
   input wire logic write_enable_n,
   input wire logic upper_lane_select_n,
   input wire logic lower_lane_select_n,
   inout wire logic [psc_pkg::DATA_W-1:0] dq,
   output logic deep
);
   logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
   initial deep = 1'b0;
   // No read is issued, so the outputs stay released.
   assign dq = 'z;
   // A lane is stored only in the select and strobe overlap.
   always @* begin
      if (!chip_select_n && !write_enable_n && power_down_select && !deep) begin
         if (!lower_lane_select_n && ^dq[7:0] !== 1'bx) mem[mem_addr][7:0] = dq[7:0];
         if (!upper_lane_select_n && ^dq[15:8] !== 1'bx) mem[mem_addr][15:8] = dq[15:8];
      end
   end
   // Deep power down follows a held-low select; contents are lost.
   always @(power_down_select) begin
      deep = 1'b0;
      if (!power_down_select) begin
         #(SUSPEND_NS);
         if (!power_down_select) begin
            deep = 1'b1;
            mem.delete();
         end
      end
   end
endmodule

// ### test/test_psram_async_write_and_power_down.sv
`timescale 1ns/10ps
module test_psram_async_write_and_power_down import psc_pkg::*;;
   logic clk = 1'b0, rst_n = 1'b0, wr_valid = 1'b0, sleep_req = 1'b0, deep;
   logic wr_ready, asleep, chip_select_n, power_down_select, write_enable_n;
   logic upper_lane_select_n, lower_lane_select_n, output_enable_n;
   // Set once the select has stood high for a read-cycle time while a write waited.
   logic saw_sb = 1'b0;
   int hi_run = 0;
   logic [ADDR_W-1:0] wr_addr = '0, mem_addr;
   logic [DATA_W-1:0] wr_data = '0, mem_dq_out;
   logic [1:0] wr_lanes = 2'h0, mem_dq_oe;
   wire [DATA_W-1:0] dq;
   int miscompares = 0, checks_done = 0, cur = 0, maxp = 0, n;
   // Each data lane carries the host value only while the host drives it.
   assign dq = {mem_dq_oe[1] ? mem_dq_out[15:8] : 8'hzz, mem_dq_oe[0] ? mem_dq_out[7:0] : 8'hzz};
   always #2.5 clk = ~clk;
   psc_host #(.SUSPEND_CYCLES(20), .WAKE_CYCLES(20), .REFRESH_CYCLES(1000)) i_dut (
      .clk, .rst_n, .wr_valid, .wr_ready, .wr_addr, .wr_data, .wr_lanes, .sleep_req, .asleep,
      .mem_addr, .chip_select_n, .power_down_select, .write_enable_n, .output_enable_n,
      .upper_lane_select_n, .lower_lane_select_n, .mem_dq_out, .mem_dq_oe);
   psc_mem_model #(.SUSPEND_NS(100)) i_mem (.mem_addr, .chip_select_n, .power_down_select,
      .write_enable_n, .upper_lane_select_n, .lower_lane_select_n, .dq, .deep);
   // Longest strobe-low run seen, in cycles.
   always @(posedge clk) begin
      cur = write_enable_n ? 0 : cur + 1;
      if (cur > maxp) maxp = cur;
      hi_run = chip_select_n ? hi_run + 1 : 0;
      if (hi_run >= RC_CYC && wr_valid) saw_sb = 1'b1;
   end
   task automatic chk(input logic ok, input string msg);
      checks_done++;
      if (!ok) begin
         miscompares++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   // Holds a write request until it is taken; valid stays up for chaining.
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] l);
      wr_addr = a;
      wr_data = d;
      wr_lanes = l;
      wr_valid = 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wr_ready !== 1'b1 && n < 3000);
      @(negedge clk);
      chk(n < 3000, "write not taken");
   endtask
   task automatic t_lanes;
      wr(21'h8, 16'h1234, 2'h3);
      wr(21'h8, 16'hffee, 2'h1);
      wr(21'h9, 16'h5a5a, 2'h3);
      wr(21'h8, 16'h77ff, 2'h2);
      wr_valid = 1'b0;
      repeat (30) @(negedge clk);
      chk(i_mem.mem[21'h8] === 16'h77ee, "lane merge");
      chk(i_mem.mem[21'h9] === 16'h5a5a, "word write");
      chk(output_enable_n === 1'b1, "output enable driven");
   endtask
   task automatic t_burst;
      // Runs on past the refresh window so that a standby slot must be inserted.
      for (int i = 0; i < 65; i++) wr(21'(32 + i), 16'(i), 2'h3);
      wr_valid = 1'b0;
      repeat (30) @(negedge clk);
      chk(maxp == WP_LONG_CYC, "no long pulse");
      chk(i_mem.mem[21'h56] === 16'h0036, "burst data");
      chk(saw_sb === 1'b1, "no standby slot in long burst");
   endtask
   task automatic t_sleep;
      sleep_req = 1'b1;
      n = 0;
      while (asleep !== 1'b1 && n < 500) begin
         @(negedge clk);
         n++;
      end
      chk(power_down_select === 1'b0, "not powered down");
      repeat (30) @(negedge clk);
      chk(deep === 1'b1 && i_mem.mem.num() == 0, "not in deep power down");
      sleep_req = 1'b0;
      wr(21'h5, 16'hc3c3, 2'h3);
      wr_valid = 1'b0;
      chk(n >= 20, "wake wait short");
      repeat (30) @(negedge clk);
      chk(i_mem.mem[21'h5] === 16'hc3c3, "write after wake");
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      t_lanes();
      t_burst();
      t_sleep();
      end_sim();
   end
   initial begin
      #50us;
      miscompares++;
      end_sim();
   end
endmodule
